// ### hdl/pfc_fault_cond.sv
// Fault-condition conditioning of one PWM generator with its AHB-Lite registers
//
// How it works
// RULE1 - Holding mode keeps fault while status set
// RULE2 - Clearing status drops held fault
// RULE3 - Stretch enable starts one-shot on rising fault
// RULE4 - Running counter ignores underlying fault level
// RULE5 - Clearing stretch enable aborts stretch at once
// RULE6 - Stretch lasts count plus one or two
// RULE7 - Stretch acts on whichever source selected
// RULE8 - Stretch disabled passes deassertion unchanged
// RULE9 - Select zero uses fault input zero only
// RULE10 - Select one uses configured input combination
// RULE11 - Software enables stretch only without holding; the logic accepts both set together
// RULE12 - Without holding, fault follows its source
// RULE13 - Enabled fault sets generator fault status
//
// The implementer's own choices: the address map and the AHB-Lite slave port.
module pfc_fault_cond (
    // Clock and reset
    input  wire logic                              hclk,
    input  wire logic                              hresetn,
    // AHB-Lite slave
    input  wire logic                              hsel,
    input  wire logic [31:0]                       haddr,
    input  wire logic [1:0]                        htrans,
    input  wire logic                              hwrite,
    input  wire logic [2:0]                        hsize,
    input  wire logic [31:0]                       hwdata,
    input  wire logic                              hready,
    output logic      [31:0]                       hrdata,
    output logic                                   hreadyout,
    output logic                                   hresp,
    // Fault pins, asynchronous to hclk
    input  wire logic [pfc_pkg::NUM_FAULT_IN-1:0]  fault_in,
    // Conditioned fault and interrupt
    output logic                                   fault_condition,
    output logic                                   irq
);

    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    pfc_pkg::pfc_aphase_t                 aph_r;            // Address phase held into data phase
    pfc_pkg::pfc_ctl_t                    ctl_r;            // generator_control fields
    logic [pfc_pkg::COUNT_W-1:0]          min_stretch_count; // Stretch length in generator ticks
    logic [pfc_pkg::NUM_FAULT_IN-1:0]     fault_source_config; // Inputs used when select is one
    logic [pfc_pkg::GEN_DIV_W-1:0]        gen_div_r;        // Generator clock divide value
    logic [pfc_pkg::INT_W-1:0]            int_status_r;     // Sticky event bits
    logic [pfc_pkg::INT_W-1:0]            int_enable_r;     // Event enables
    logic [pfc_pkg::INT_W-1:0]            int_clr;          // Clear strobe from a write
    logic [pfc_pkg::INT_W-1:0]            int_set;          // Events this cycle
    logic [pfc_pkg::NUM_FAULT_IN-1:0]     sync1_r;          // First synchroniser stage
    logic [pfc_pkg::NUM_FAULT_IN-1:0]     sync2_r;          // Second synchroniser stage
    logic [pfc_pkg::GEN_DIV_W-1:0]        div_cnt_r;        // Divider counter
    logic                                 generator_clock;  // One-cycle tick at generator rate
    logic                                 src_fault;        // Selected raw fault source
    logic                                 base_cond;        // Source plus holding
    logic                                 base_cond_d_r;    // Previous base_cond for edge detect
    logic                                 base_rise;        // Rising edge of base_cond
    pfc_pkg::pfc_str_state_t              str_state_r;      // One-shot state
    logic [pfc_pkg::COUNT_W-1:0]          str_cnt_r;        // One-shot remaining ticks
    logic                                 str_end;          // Stretch ran out this cycle
    logic                                 cond_nxt;         // Next conditioned fault
    logic                                 fault_r;          // Registered conditioned fault
    logic [31:0]                          rdata_nxt;        // Read data for the next data phase
    logic [31:0]                          hrdata_r;         // Registered read data
    logic                                 wr_en;            // Data phase write this cycle

    // ------------------------------------------------------------------
    // AHB-Lite slave
    // ------------------------------------------------------------------

    // Zero wait states: every access completes in its first data phase
    assign hreadyout = 1'b1;
    assign hresp     = pfc_pkg::HRESP_OKAY;
    assign hrdata    = hrdata_r;

    // Capture the address phase when the bus moves on
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            aph_r <= '0;
        end else if (hready) begin
            // Only NONSEQ/SEQ mark a real transfer; IDLE and BUSY are ignored
            aph_r.valid <= hsel && htrans[1];
            aph_r.write <= hwrite;
            aph_r.addr  <= haddr[pfc_pkg::ADDR_W-1:0];
        end
    end

    // Writes land in the data phase, when hwdata is valid
    assign wr_en = aph_r.valid && aph_r.write;

    // Read mux evaluated in the address phase, registered for the data phase
    always_comb begin
        rdata_nxt = '0;
        case (haddr[pfc_pkg::ADDR_W-1:0])
            pfc_pkg::OFS_GEN_CTL: begin
                rdata_nxt[pfc_pkg::CTL_HOLD_BIT]    = ctl_r.hold;
                rdata_nxt[pfc_pkg::CTL_STRETCH_BIT] = ctl_r.stretch_en;
                rdata_nxt[pfc_pkg::CTL_SRC_BIT]     = ctl_r.src_sel;
            end
            pfc_pkg::OFS_MIN_STR: begin
                rdata_nxt[pfc_pkg::COUNT_W-1:0] = min_stretch_count;
            end
            pfc_pkg::OFS_FLT_CFG: begin
                rdata_nxt[pfc_pkg::NUM_FAULT_IN-1:0] = fault_source_config;
            end
            pfc_pkg::OFS_INT_STAT: begin
                rdata_nxt[pfc_pkg::INT_W-1:0] = int_status_r;
            end
            pfc_pkg::OFS_INT_EN: begin
                rdata_nxt[pfc_pkg::INT_W-1:0] = int_enable_r;
            end
            pfc_pkg::OFS_FLT_STAT: begin
                rdata_nxt[pfc_pkg::STAT_COND_BIT] = fault_r;
                rdata_nxt[pfc_pkg::STAT_RAW_BIT]  = src_fault;
                rdata_nxt[pfc_pkg::STAT_RUN_BIT]  = (str_state_r == pfc_pkg::PFC_STRETCH);
            end
            pfc_pkg::OFS_GEN_DIV: begin
                rdata_nxt[pfc_pkg::GEN_DIV_W-1:0] = gen_div_r;
            end
            default: begin
                // Unmapped and write-only offsets read as zero
                rdata_nxt = '0;
            end
        endcase
    end

    // Read data register; held between reads
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata_r <= '0;
        end else if (hready && hsel && htrans[1] && !hwrite) begin
            hrdata_r <= rdata_nxt;
        end
    end

    // ------------------------------------------------------------------
    // Configuration registers
    // ------------------------------------------------------------------

    // generator_control: holding, stretch enable and source select
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctl_r <= '0;
        end else if (wr_en && aph_r.addr == pfc_pkg::OFS_GEN_CTL) begin
            ctl_r.hold       <= hwdata[pfc_pkg::CTL_HOLD_BIT];
            ctl_r.stretch_en <= hwdata[pfc_pkg::CTL_STRETCH_BIT];
            ctl_r.src_sel    <= hwdata[pfc_pkg::CTL_SRC_BIT];
        end
    end

    // Stretch length register
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            min_stretch_count <= pfc_pkg::RST_MIN_STR;
        end else if (wr_en && aph_r.addr == pfc_pkg::OFS_MIN_STR) begin
            min_stretch_count <= hwdata[pfc_pkg::COUNT_W-1:0];
        end
    end

    // Per-generator input selection
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            fault_source_config <= pfc_pkg::RST_FLT_CFG;
        end else if (wr_en && aph_r.addr == pfc_pkg::OFS_FLT_CFG) begin
            fault_source_config <= hwdata[pfc_pkg::NUM_FAULT_IN-1:0];
        end
    end

    // Generator clock divide value
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            gen_div_r <= pfc_pkg::RST_GEN_DIV;
        end else if (wr_en && aph_r.addr == pfc_pkg::OFS_GEN_DIV) begin
            gen_div_r <= hwdata[pfc_pkg::GEN_DIV_W-1:0];
        end
    end

    // Interrupt enables
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            int_enable_r <= pfc_pkg::RST_INT;
        end else if (wr_en && aph_r.addr == pfc_pkg::OFS_INT_EN) begin
            int_enable_r <= hwdata[pfc_pkg::INT_W-1:0];
        end
    end

    // ------------------------------------------------------------------
    // Generator clock divider
    // ------------------------------------------------------------------

    // Tick once every gen_div_r+1 hclk cycles; zero gives a tick each cycle
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            div_cnt_r <= '0;
        end else if (div_cnt_r >= gen_div_r) begin
            div_cnt_r <= '0;
        end else begin
            div_cnt_r <= div_cnt_r + 1'b1;
        end
    end

    assign generator_clock = (div_cnt_r >= gen_div_r);

    // ------------------------------------------------------------------
    // Fault input synchroniser and source select
    // ------------------------------------------------------------------

    // Two flops per pin; only the second stage feeds logic
    generate
        for (genvar i = 0; i < pfc_pkg::NUM_FAULT_IN; i++) begin : g_sync
            always_ff @(posedge hclk or negedge hresetn) begin
                if (!hresetn) begin
                    sync1_r[i] <= 1'b0;
                    sync2_r[i] <= 1'b0;
                end else begin
                    sync1_r[i] <= fault_in[i];
                    sync2_r[i] <= sync1_r[i];
                end
            end
        end
    endgenerate

    // Pick the fault source for this generator
    always_comb begin
        if (ctl_r.src_sel) begin
            src_fault = |(sync2_r & fault_source_config);     // [RULE10]
        end else begin
            src_fault = sync2_r[0];                           // [RULE9]
        end
    end

    // Holding folds the sticky status bit back into the condition;
    // without holding the condition simply follows the source
    assign base_cond = src_fault ||
                       (ctl_r.hold && int_status_r[pfc_pkg::INT_FAULT_BIT]); // [RULE1] [RULE2] [RULE12]

    // ------------------------------------------------------------------
    // Interrupt status
    // ------------------------------------------------------------------

    // Clear strobe from the write-only clear register
    assign int_clr = (wr_en && aph_r.addr == pfc_pkg::OFS_INT_CLR) ?
                     hwdata[pfc_pkg::INT_W-1:0] : '0;

    // Events: a live fault while enabled, and a stretch running out
    always_comb begin
        int_set = '0;
        int_set[pfc_pkg::INT_FAULT_BIT]   = src_fault && int_enable_r[pfc_pkg::INT_FAULT_BIT]; // [RULE13]
        int_set[pfc_pkg::INT_STR_END_BIT] = str_end && int_enable_r[pfc_pkg::INT_STR_END_BIT];
    end

    // Sticky bits; a set in the same cycle as a clear wins
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            int_status_r <= pfc_pkg::RST_INT;
        end else begin
            int_status_r <= (int_status_r & ~int_clr) | int_set; // [RULE2]
        end
    end

    // Level interrupt while any enabled status bit is set
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq <= 1'b0;
        end else begin
            irq <= |(((int_status_r & ~int_clr) | int_set) & int_enable_r);
        end
    end

    // ------------------------------------------------------------------
    // Minimum period one-shot
    // ------------------------------------------------------------------

    // Edge detector on the (already synchronised) base condition
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            base_cond_d_r <= 1'b0;
        end else begin
            base_cond_d_r <= base_cond;
        end
    end

    assign base_rise = base_cond && !base_cond_d_r;

    // Ends at the last generator tick of the count
    assign str_end = (str_state_r == pfc_pkg::PFC_STRETCH) && ctl_r.stretch_en &&
                     generator_clock && (str_cnt_r == '0);

    // Counter loads on a rising edge of whichever source is selected.
    // The rise is seen on any hclk cycle, between generator ticks, hence the extra tick
    // of uncertainty in the stretched length.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            str_state_r <= pfc_pkg::PFC_IDLE;
            str_cnt_r   <= '0;
        end else begin
            case (str_state_r)
                pfc_pkg::PFC_IDLE: begin
                    // Start only while enabled [RULE3] [RULE7]
                    if (ctl_r.stretch_en && base_rise) begin
                        str_state_r <= pfc_pkg::PFC_STRETCH;
                        str_cnt_r   <= min_stretch_count;          // [RULE6]
                    end
                end
                pfc_pkg::PFC_STRETCH: begin
                    if (!ctl_r.stretch_en) begin
                        // Software pulled the enable: abort now
                        str_state_r <= pfc_pkg::PFC_IDLE;        // [RULE5]
                        str_cnt_r   <= '0;
                    end else if (generator_clock) begin
                        // Count whole ticks, ignoring the fault level [RULE4]
                        if (str_cnt_r == '0) begin
                            str_state_r <= pfc_pkg::PFC_IDLE;    // [RULE6]
                        end else begin
                            str_cnt_r <= str_cnt_r - 1'b1;
                        end
                    end
                end
                default: begin
                    str_state_r <= pfc_pkg::PFC_IDLE;
                    str_cnt_r   <= '0;
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Conditioned fault output
    // ------------------------------------------------------------------

    // Stretch ORs in only while enabled and running; otherwise the
    // deassertion of the base condition passes straight through.
    // Note that holding plus stretch is legal; the stretch still keeps the output
    // high if the held status is cleared before the count runs out. [RULE11]
    always_comb begin
        if (ctl_r.stretch_en && (str_state_r == pfc_pkg::PFC_STRETCH)) begin
            cond_nxt = 1'b1;                                   // [RULE4]
        end else if (ctl_r.stretch_en && base_rise) begin
            cond_nxt = 1'b1;                                   // [RULE3]
        end else begin
            cond_nxt = base_cond;                              // [RULE8] [RULE5] [RULE12]
        end
    end

    // Registered so the output is glitch free
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            fault_r <= 1'b0;
        end else begin
            fault_r <= cond_nxt;
        end
    end

    assign fault_condition = fault_r;

endmodule : pfc_fault_cond

// ### hdl/pfc_pkg.sv
// Package of constants, register map and carrier types for the fault conditioner
package pfc_pkg;

    // ------------------------------------------------------------------
    // Sizes
    // ------------------------------------------------------------------
    localparam int NUM_FAULT_IN  = 4;      // Fault pins reaching this generator
    localparam int COUNT_W       = 16;     // Width of the minimum stretch count
    localparam int ADDR_W        = 12;     // Decoded address bits
    localparam int INT_W         = 2;      // Number of interrupt events
    localparam int GEN_DIV_W     = 8;      // Width of the generator clock divider

    // ------------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------------
    localparam logic [ADDR_W-1:0] OFS_GEN_CTL    = 12'h040; // generator_control
    localparam logic [ADDR_W-1:0] OFS_MIN_STR    = 12'h044; // min_fault_stretch_register
    localparam logic [ADDR_W-1:0] OFS_FLT_CFG    = 12'h048; // fault_source_config
    localparam logic [ADDR_W-1:0] OFS_INT_STAT   = 12'h04c; // interrupt_status_register, RO
    localparam logic [ADDR_W-1:0] OFS_INT_CLR    = 12'h050; // Interrupt clear, WO
    localparam logic [ADDR_W-1:0] OFS_INT_EN     = 12'h054; // interrupt_enable_register
    localparam logic [ADDR_W-1:0] OFS_FLT_STAT   = 12'h058; // Live fault state, RO
    localparam logic [ADDR_W-1:0] OFS_GEN_DIV    = 12'h05c; // Generator clock divider

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int CTL_HOLD_BIT    = 18;   // Fault holding (latch) select
    localparam int CTL_STRETCH_BIT = 17;   // min_fault_stretch_enable
    localparam int CTL_SRC_BIT     = 16;   // fault_source_select
    localparam int INT_FAULT_BIT   = 0;    // generator_fault_int_status
    localparam int INT_STR_END_BIT = 1;    // Stretch finished event
    localparam int STAT_COND_BIT   = 0;    // Conditioned fault output
    localparam int STAT_RAW_BIT    = 1;    // Selected source before stretch
    localparam int STAT_RUN_BIT    = 2;    // One-shot counter running

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic [COUNT_W-1:0]      RST_MIN_STR = 16'h0000;
    localparam logic [NUM_FAULT_IN-1:0] RST_FLT_CFG = 4'h0;
    localparam logic [GEN_DIV_W-1:0]    RST_GEN_DIV = 8'h00;
    localparam logic [INT_W-1:0]        RST_INT     = 2'h0;

    // ------------------------------------------------------------------
    // AHB encodings
    // ------------------------------------------------------------------
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic       HRESP_OKAY    = 1'h0;

    // ------------------------------------------------------------------
    // Carrier types
    // ------------------------------------------------------------------
    // Control bits that steer the conditioner
    typedef struct packed {
        logic hold;        // Keep fault while status bit set
        logic stretch_en;  // min_fault_stretch_enable
        logic src_sel;     // fault_source_select
    } pfc_ctl_t;

    // Latched address phase of one AHB transfer
    typedef struct packed {
        logic              valid;
        logic              write;
        logic [ADDR_W-1:0] addr;
    } pfc_aphase_t;

    // One-shot counter state
    typedef enum logic {
        PFC_IDLE,
        PFC_STRETCH
    } pfc_str_state_t;

endpackage : pfc_pkg

// ### test/pfc_checker.sv
// Port-level checks of the fault conditioner
module pfc_checker (
    // Clock and reset
    input wire logic        hclk,
    input wire logic        hresetn,
    // Bus side
    input wire logic        hsel,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic [31:0] hrdata,
    input wire logic        hreadyout,
    input wire logic        hresp,
    // Fault side
    input wire logic [3:0]  fault_in,
    input wire logic        fault_condition,
    input wire logic        irq
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    // ----------
    // Write age: irq may only change on its own soon after a write
    // ----------
    logic [2:0] wr_age_r; // Saturates at 7 so it never wraps back
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) wr_age_r <= 3'h7;
        else if (hsel && htrans[1] && hwrite && hreadyout) wr_age_r <= 3'h0;
        else if (wr_age_r != 3'h7) wr_age_r <= wr_age_r + 3'h1;
    end
    chk_ready_high: assert property (hreadyout) else $error("hreadyout low");
    chk_resp_okay: assert property (hresp == pfc_pkg::HRESP_OKAY) else $error("hresp not okay");
    chk_reset_quiet: assert property ($rose(hresetn) |-> !fault_condition && !irq && hrdata == 32'h0)
        else $error("not quiet after reset");
    chk_rise_cause: assert property ($rose(fault_condition) |-> $past(|fault_in, 3))
        else $error("fault without pin");
    chk_irq_cause: assert property ($rose(irq) |-> $past(|fault_in, 3) || wr_age_r < 3'h6)
        else $error("irq without cause");
    chk_irq_clear: assert property ($fell(irq) |-> wr_age_r < 3'h6)
        else $error("irq fell, no write");
    chk_rdata_hold: assert property (!(hsel && htrans[1] && !hwrite && hreadyout) |=> $stable(hrdata))
        else $error("hrdata moved");
    chk_rdata_upper: assert property (hrdata[31:19] == 13'h0) else $error("unused read bits set");
    cov_fault: cover property ($rose(fault_condition));
    cov_irq_up: cover property ($rose(irq));
    cov_irq_down: cover property ($fell(irq));
endmodule : pfc_checker

// ### test/pfc_fault_cond_tb.sv
// Self-checking bench of the fault conditioner
module pfc_fault_cond_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
    logic [1:0]  htrans = 2'h0;
    logic [2:0]  hsize = 3'h0;
    logic        hreadyout, hresp, fault_condition, irq;
    logic [3:0]  fault_in;
    int          err_count = 0, comparisons = 0, n;
    pfc_fault_cond dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .fault_in(fault_in), .fault_condition(fault_condition), .irq(irq));
    pfc_fault_src src (.hclk(hclk), .fault_in(fault_in));
    initial forever #25 hclk = ~hclk; // 20 MHz
    // ----------
    // Shared tasks
    // ----------
    task automatic end_sim();
        $display("Mismatches %0d, comparisons %0d", err_count, comparisons);
        if (err_count == 0 && comparisons > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : end_sim
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    // Bounded wait for hready; a hang ends the run
    task automatic wait_ready();
        for (int k = 0; k < 17; k++) begin
            @(posedge hclk);
            if (hreadyout === 1'b1) return;
        end
        err_count++;
        end_sim();
    endtask : wait_ready
    // One single AHB-Lite word transfer
    task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] wd, output logic [31:0] rd);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= pfc_pkg::HTRANS_NONSEQ;
        hwrite <= wr;
        hsize <= 3'h2;
        haddr <= {20'h0, a};
        wait_ready();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        wait_ready();
        rd = hrdata;
    endtask : bus
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] x;
        bus(1'b1, a, d, x);
    endtask : wr
    task automatic rd_chk(input string w, input logic [11:0] a, input logic [31:0] e);
        logic [31:0] x;
        bus(1'b0, a, 32'h0, x);
        check(w, x, e);
    endtask : rd_chk
    // Edges until fault_condition reaches v, bounded by mx
    task automatic wait_fc(input logic v, input int mx, output int k);
        k = 0;
        do begin
            @(posedge hclk);
            #1;
            k++;
        end while (fault_condition !== v && k < mx);
    endtask : wait_fc
    // ----------
    // Scenarios
    // ----------
    task automatic t_regs();
        logic [11:0] ofs [8] = '{12'h040, 12'h044, 12'h048, 12'h04c, 12'h054, 12'h058, 12'h05c, 12'h0fc};
        foreach (ofs[i]) rd_chk("reset value", ofs[i], 32'h0);
        wr(pfc_pkg::OFS_GEN_CTL, 32'hfffbffff);
        rd_chk("control fields", pfc_pkg::OFS_GEN_CTL, 32'h00030000);
        wr(pfc_pkg::OFS_GEN_CTL, 32'h0);
    endtask : t_regs
    task automatic t_follow();
        wr(pfc_pkg::OFS_INT_EN, 32'h1);
        src.drive(4'h2);
        wait_fc(1'b1, 6, n);
        check("pin1 ignored", fault_condition, 32'h0);
        src.drive(4'h1);
        wait_fc(1'b1, 8, n);
        check("rise lag", n, 32'd3);
        src.drive(4'h0);
        wait_fc(1'b0, 8, n);
        check("fall lag", n, 32'd3);
        check("irq raised", irq, 32'h1);
        rd_chk("status", pfc_pkg::OFS_INT_STAT, 32'h1);
        wr(pfc_pkg::OFS_INT_EN, 32'h0);
        rd_chk("masked", pfc_pkg::OFS_INT_STAT, 32'h1);
        check("irq masked", irq, 32'h0);
        wr(pfc_pkg::OFS_INT_CLR, 32'h1);
        wr(pfc_pkg::OFS_INT_EN, 32'h1);
        rd_chk("cleared", pfc_pkg::OFS_INT_STAT, 32'h0);
    endtask : t_follow
    task automatic t_src_cfg();
        wr(pfc_pkg::OFS_FLT_CFG, 32'h4);
        wr(pfc_pkg::OFS_GEN_CTL, 32'h00010000);
        src.drive(4'h1);
        wait_fc(1'b1, 6, n);
        check("pin0 not configured", fault_condition, 32'h0);
        src.drive(4'h4);
        wait_fc(1'b1, 8, n);
        check("configured pin", n, 32'd3);
        src.drive(4'h0);
        wait_fc(1'b0, 8, n);
        wr(pfc_pkg::OFS_INT_CLR, 32'h1);
    endtask : t_src_cfg
    task automatic t_hold();
        wr(pfc_pkg::OFS_GEN_CTL, 32'h00040000);
        src.pulse(4'h1, 2);
        repeat (10) @(posedge hclk);
        #1;
        check("held", fault_condition, 32'h1);
        wr(pfc_pkg::OFS_INT_CLR, 32'h1);
        wait_fc(1'b0, 4, n);
        check("hold released", fault_condition, 32'h0);
    endtask : t_hold
    task automatic t_stretch(input int d, input int cnt);
        wr(pfc_pkg::OFS_INT_EN, 32'h3);
        wr(pfc_pkg::OFS_GEN_DIV, d);
        wr(pfc_pkg::OFS_MIN_STR, cnt);
        wr(pfc_pkg::OFS_GEN_CTL, 32'h00030000);
        src.pulse(4'h4, 1);
        wait_fc(1'b1, 8, n);
        wait_fc(1'b0, 600, n);
        check("stretch min", n >= (cnt + 1) * (d + 1), 32'h1);
        check("stretch max", n <= (cnt + 2) * (d + 1), 32'h1);
        rd_chk("stretch end", pfc_pkg::OFS_INT_STAT, 32'h3);
        wr(pfc_pkg::OFS_INT_CLR, 32'h3);
    endtask : t_stretch
    task automatic t_abort();
        wr(pfc_pkg::OFS_MIN_STR, 32'd200);
        src.pulse(4'h4, 1);
        wait_fc(1'b1, 8, n);
        wr(pfc_pkg::OFS_GEN_CTL, 32'h00010000);
        wait_fc(1'b0, 3, n);
        check("stretch aborted", fault_condition, 32'h0);
        wr(pfc_pkg::OFS_INT_CLR, 32'h1);
    endtask : t_abort
    initial begin
        repeat (12) @(posedge hclk);
        hresetn <= 1'b1;
        t_regs();
        t_follow();
        t_src_cfg();
        t_hold();
        t_stretch(0, 5);
        t_stretch(1, 3);
        t_abort();
        end_sim();
    end
endmodule : pfc_fault_cond_tb
bind pfc_fault_cond pfc_checker u_chk (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .htrans(htrans),
    .hwrite(hwrite), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .fault_in(fault_in), .fault_condition(fault_condition), .irq(irq));

// ### test/pfc_fault_src.sv
// Model of the power-stage fault pins
module pfc_fault_src (
    // Clock
    input wire logic                        hclk,
    // Pins towards the conditioner
    output logic [pfc_pkg::NUM_FAULT_IN-1:0] fault_in
);
    timeunit 1ns;
    timeprecision 1ns;
    initial fault_in = '0; // Pins idle low, no fault
    // New pin levels land just after a rising edge
    task automatic drive(input logic [pfc_pkg::NUM_FAULT_IN-1:0] v);
        @(posedge hclk);
        fault_in <= v;
    endtask : drive
    // Short glitch: pins high for n cycles, then back to idle
    task automatic pulse(input logic [pfc_pkg::NUM_FAULT_IN-1:0] v, input int n);
        drive(v);
        repeat (n) @(posedge hclk);
        fault_in <= '0;
    endtask : pulse
endmodule : pfc_fault_src
